// ---- core/cpfu_pkg.sv ----
// Functional notes
// - ten general purpose pins, each given one selectable function by configuration
// - pins 2, 3, 4 and 6 keep working while the interface supply is off
// - a pin set as output drives the commanded high or low level
// - a pin set as input senses and reports the applied level
// - network status output on pins 1,2,4,5,7,8,9,10 shows network state
// - module status on pins 2 or 4: low when off, high otherwise
// - pin 6 as SIM detect gates the SIM interface when hot insertion is on
// - SIM detect low means card absent, high means card present
// - ring indication on pins 1,2,4,5,7,8,9,10 follows the ring indicator line
// - pin 3 or 6 wakes the module once power saving enables it
// - fast power-off pin has pull-down; rising edge triggers fast shutdown
// - memory-safe power-off pin has pull-down; rising edge triggers safe shutdown
// - pin 1 disabled is tri-state with pull-up, its default function
// - other pins disabled are tri-state with pull-down, default for pins 2 to 10
package cpfu_pkg;
  // ==========================================================
  // sizes and register map
  localparam int         CPFU_NPIN      = 10;
  localparam int         CPFU_NEV       = 5;
  localparam logic [7:0] CPFU_OFF_FUNC0 = 8'h00;
  localparam logic [7:0] CPFU_OFF_FLAST = 8'h24;
  localparam logic [7:0] CPFU_OFF_OUT   = 8'h28;
  localparam logic [7:0] CPFU_OFF_IN    = 8'h2C;
  localparam logic [7:0] CPFU_OFF_CTRL  = 8'h30;
  localparam logic [7:0] CPFU_OFF_IST   = 8'h34;
  localparam logic [7:0] CPFU_OFF_ICLR  = 8'h38;
  localparam logic [7:0] CPFU_OFF_IEN   = 8'h3C;
  localparam int         CPFU_CTRL_PSV  = 0;
  localparam int         CPFU_CTRL_HOT  = 1;
  localparam int         CPFU_EV_SIM    = 0;
  localparam int         CPFU_EV_FAST   = 1;
  localparam int         CPFU_EV_MEM    = 2;
  localparam int         CPFU_EV_WAKE   = 3;
  localparam int         CPFU_EV_REJ    = 4;
  // ==========================================================
  // pin masks, bit 0 is pin 1
  localparam logic [9:0] CPFU_M_ALL  = 10'h3FF;
  localparam logic [9:0] CPFU_M_IND  = 10'h3DB;
  localparam logic [9:0] CPFU_M_MOD  = 10'h00A;
  localparam logic [9:0] CPFU_M_SIM  = 10'h020;
  localparam logic [9:0] CPFU_M_PWR  = 10'h024;
  localparam logic [9:0] CPFU_M_PU   = 10'h001;
  localparam logic [9:0] CPFU_M_PD   = 10'h3FE;
  localparam logic [9:0] CPFU_M_AON  = 10'h02E;
  // ==========================================================
  // pin functions
  typedef enum logic [3:0] {
    CPFU_FN_OUT  = 4'b0000,
    CPFU_FN_IN   = 4'b0001,
    CPFU_FN_NET  = 4'b0010,
    CPFU_FN_MOD  = 4'b0011,
    CPFU_FN_SIM  = 4'b0100,
    CPFU_FN_RING = 4'b0101,
    CPFU_FN_WAKE = 4'b0110,
    CPFU_FN_FAST = 4'b0111,
    CPFU_FN_MEM  = 4'b1000,
    CPFU_FN_DPU  = 4'b1001,
    CPFU_FN_DPD  = 4'b1010
  } cpfu_func_e;
  typedef struct packed {
    logic oe;
    logic lvl;
    logic pu;
    logic pd;
  } cpfu_drive_s;
  // pins on which a function may be placed
  function automatic logic [9:0] cpfu_allowed(input logic [3:0] f);
    case (f)
      CPFU_FN_OUT, CPFU_FN_IN:                  cpfu_allowed = CPFU_M_ALL;
      CPFU_FN_NET, CPFU_FN_RING:                cpfu_allowed = CPFU_M_IND;
      CPFU_FN_MOD:                              cpfu_allowed = CPFU_M_MOD;
      CPFU_FN_SIM:                              cpfu_allowed = CPFU_M_SIM;
      CPFU_FN_WAKE, CPFU_FN_FAST, CPFU_FN_MEM:  cpfu_allowed = CPFU_M_PWR;
      CPFU_FN_DPU:                              cpfu_allowed = CPFU_M_PU;
      CPFU_FN_DPD:                              cpfu_allowed = CPFU_M_PD;
      default:                                  cpfu_allowed = 10'h000;
    endcase
  endfunction : cpfu_allowed
endpackage : cpfu_pkg

// ---- core/cpfu_top.sv ----
`timescale 1ns/1ps
module cpfu_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [cpfu_pkg::CPFU_NPIN-1:0] gpio_in,
  output logic      [cpfu_pkg::CPFU_NPIN-1:0] gpio_out,
  output logic      [cpfu_pkg::CPFU_NPIN-1:0] gpio_oe,
  output logic      [cpfu_pkg::CPFU_NPIN-1:0] gpio_pu,
  output logic      [cpfu_pkg::CPFU_NPIN-1:0] gpio_pd,
  input  wire logic                          vint_on,
  input  wire logic                          module_on,
  input  wire logic                          net_status_lvl,
  input  wire logic                          ring_indicator_line,
  output logic                               sim_present,
  output logic                               sim_if_enable,
  output logic                               wake_req,
  output logic                               fast_shutdown,
  output logic                               memory_safe_shutdown,
  output logic                               irq
);
  localparam int N = cpfu_pkg::CPFU_NPIN;
  localparam int E = cpfu_pkg::CPFU_NEV;

  // ==========================================================
  // apb slave
  logic [3:0]            func_ff [N];
  logic [N-1:0]          out_lvl_ff;
  logic [1:0]            ctrl_ff;
  logic [E-1:0]          ist_ff;
  logic [E-1:0]          ien_ff;
  logic [N-1:0]          in_lvl_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic [31:0]           prdata_ff;
  logic                  acc;
  logic                  done;
  logic                  func_hit;
  logic [3:0]            func_idx;
  logic                  func_bad;
  logic [N-1:0]          allow_mask;
  logic                  mapped;
  logic [31:0]           nxt_rdata;

  assign acc      = psel & penable & ~pready_ff;
  assign done     = psel & penable & pready_ff;
  assign func_hit = (paddr <= cpfu_pkg::CPFU_OFF_FLAST) && (paddr[1:0] == 2'h0);
  assign func_idx = paddr[5:2];
  // a function call result cannot be bit-selected, so the mask is a net of its own
  assign allow_mask = cpfu_pkg::cpfu_allowed(pwdata[3:0]);
  assign func_bad = func_hit && pwrite && !allow_mask[func_idx];
  assign mapped   = func_hit || (paddr == cpfu_pkg::CPFU_OFF_OUT) ||
                    (paddr == cpfu_pkg::CPFU_OFF_IN) || (paddr == cpfu_pkg::CPFU_OFF_CTRL) ||
                    (paddr == cpfu_pkg::CPFU_OFF_IST) || (paddr == cpfu_pkg::CPFU_OFF_ICLR) ||
                    (paddr == cpfu_pkg::CPFU_OFF_IEN);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (func_hit) begin
      nxt_rdata[3:0] = func_ff[func_idx];
    end else begin
      case (paddr)
        cpfu_pkg::CPFU_OFF_OUT:  nxt_rdata[N-1:0] = out_lvl_ff;
        cpfu_pkg::CPFU_OFF_IN:   nxt_rdata[N-1:0] = in_lvl_ff;
        cpfu_pkg::CPFU_OFF_CTRL: nxt_rdata[1:0]   = ctrl_ff;
        cpfu_pkg::CPFU_OFF_IST:  nxt_rdata[E-1:0] = ist_ff;
        cpfu_pkg::CPFU_OFF_IEN:  nxt_rdata[E-1:0] = ien_ff;
        default:                 nxt_rdata        = 32'h0000_0000;
      endcase
    end
  end

  // one wait state: data and error are registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc & (~mapped | func_bad);
      if (acc && !pwrite) begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        func_ff[i] <= (i == 0) ? cpfu_pkg::CPFU_FN_DPU : cpfu_pkg::CPFU_FN_DPD;
      end
    end else if (done && pwrite && func_hit && !func_bad) begin
      func_ff[func_idx] <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lvl_ff <= '0;
      ctrl_ff    <= 2'b00;
      ien_ff     <= '0;
    end else if (done && pwrite) begin
      if (paddr == cpfu_pkg::CPFU_OFF_OUT)  out_lvl_ff <= pwdata[N-1:0];
      if (paddr == cpfu_pkg::CPFU_OFF_CTRL) ctrl_ff    <= pwdata[1:0];
      if (paddr == cpfu_pkg::CPFU_OFF_IEN)  ien_ff     <= pwdata[E-1:0];
    end
  end

  // ==========================================================
  // pin input synchronisers
  logic [N-1:0] s1_ff, s2_ff, s3_ff;
  logic [N-1:0] prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      in_lvl_ff <= '0;
      prev_ff   <= '0;
    end else begin
      s1_ff     <= gpio_in;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      // level accepted once two stages agree
      in_lvl_ff <= (s2_ff & s3_ff) | (in_lvl_ff & (s2_ff | s3_ff));
      prev_ff   <= in_lvl_ff;
    end
  end

  // ==========================================================
  // pin drive and function decode
  cpfu_pkg::cpfu_drive_s drv_ff [N];
  logic [N-1:0] rise;
  logic [N-1:0] is_sim, is_wake, is_fast, is_mem;

  assign rise = in_lvl_ff & ~prev_ff;

  generate
    for (genvar g = 0; g < N; g++) begin : g_pin
      cpfu_pkg::cpfu_drive_s nxt_drv;
      logic powered;
      assign powered    = vint_on | cpfu_pkg::CPFU_M_AON[g];
      assign is_sim[g]  = func_ff[g] == cpfu_pkg::CPFU_FN_SIM;
      assign is_wake[g] = func_ff[g] == cpfu_pkg::CPFU_FN_WAKE;
      assign is_fast[g] = func_ff[g] == cpfu_pkg::CPFU_FN_FAST;
      assign is_mem[g]  = func_ff[g] == cpfu_pkg::CPFU_FN_MEM;
      always_comb begin
        nxt_drv = '0;
        case (func_ff[g])
          cpfu_pkg::CPFU_FN_OUT:  nxt_drv = '{1'b1, out_lvl_ff[g], 1'b0, 1'b0};
          cpfu_pkg::CPFU_FN_NET:  nxt_drv = '{1'b1, net_status_lvl, 1'b0, 1'b0};
          cpfu_pkg::CPFU_FN_MOD:  nxt_drv = '{1'b1, module_on, 1'b0, 1'b0};
          cpfu_pkg::CPFU_FN_RING: nxt_drv = '{1'b1, ring_indicator_line, 1'b0, 1'b0};
          cpfu_pkg::CPFU_FN_FAST,
          cpfu_pkg::CPFU_FN_MEM:  nxt_drv = '{1'b0, 1'b0, 1'b0, 1'b1};
          cpfu_pkg::CPFU_FN_DPU:  nxt_drv = '{1'b0, 1'b0, 1'b1, 1'b0};
          cpfu_pkg::CPFU_FN_DPD:  nxt_drv = '{1'b0, 1'b0, 1'b0, 1'b1};
          default:                nxt_drv = '0;
        endcase
        // unpowered pins float: no drive, no pull
        if (!powered) nxt_drv = '0;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drv_ff[g] <= (g == 0) ? cpfu_pkg::cpfu_drive_s'(4'h2) : cpfu_pkg::cpfu_drive_s'(4'h1);
        end else begin
          drv_ff[g] <= nxt_drv;
        end
      end
      assign gpio_oe[g]  = drv_ff[g].oe;
      assign gpio_out[g] = drv_ff[g].lvl;
      assign gpio_pu[g]  = drv_ff[g].pu;
      assign gpio_pd[g]  = drv_ff[g].pd;
    end
  endgenerate

  // ==========================================================
  // system functions and events
  logic [E-1:0] ev;
  logic         sim_ff, sim_en_ff, wake_ff, fast_ff, mem_ff, irq_ff;
  logic         nxt_sim;

  assign nxt_sim = |(is_sim & in_lvl_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sim_ff    <= 1'b0;
      sim_en_ff <= 1'b1;
      wake_ff   <= 1'b0;
      fast_ff   <= 1'b0;
      mem_ff    <= 1'b0;
    end else begin
      sim_ff    <= nxt_sim;
      sim_en_ff <= ctrl_ff[cpfu_pkg::CPFU_CTRL_HOT] ? nxt_sim : 1'b1;
      wake_ff   <= ctrl_ff[cpfu_pkg::CPFU_CTRL_PSV] & |(is_wake & in_lvl_ff);
      fast_ff   <= |(is_fast & rise);
      mem_ff    <= |(is_mem & rise);
    end
  end

  always_comb begin
    ev = '0;
    ev[cpfu_pkg::CPFU_EV_SIM]  = nxt_sim ^ sim_ff;
    ev[cpfu_pkg::CPFU_EV_FAST] = |(is_fast & rise);
    ev[cpfu_pkg::CPFU_EV_MEM]  = |(is_mem & rise);
    ev[cpfu_pkg::CPFU_EV_WAKE] = ctrl_ff[cpfu_pkg::CPFU_CTRL_PSV] & |(is_wake & rise);
    ev[cpfu_pkg::CPFU_EV_REJ]  = done & func_bad;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (done && pwrite && paddr == cpfu_pkg::CPFU_OFF_ICLR) begin
        ist_ff <= (ist_ff & ~pwdata[E-1:0]) | ev;
      end else begin
        ist_ff <= ist_ff | ev;
      end
      irq_ff <= |(ist_ff & ien_ff);
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign sim_present          = sim_ff;
  assign sim_if_enable        = sim_en_ff;
  assign wake_req             = wake_ff;
  assign fast_shutdown        = fast_ff;
  assign memory_safe_shutdown = mem_ff;
  assign irq                  = irq_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reject_keeps_a: assert property (done && func_bad |=>
    func_ff[$past(func_idx)] == $past(func_ff[func_idx]) && pslverr == 1'b0 &&
    ist_ff[cpfu_pkg::CPFU_EV_REJ]) else $error("bad function stored");
  func_write_a: assert property (done && pwrite && func_hit && !func_bad
    |=> func_ff[$past(func_idx)] == $past(pwdata[3:0])) else $error("function not stored");
  fast_pulse_a: assert property (fast_shutdown |-> $past(|(is_fast & rise))
    ##1 !fast_shutdown || $past(|(is_fast & rise))) else $error("fast shutdown wrong");
  mem_pulse_a: assert property (|(is_mem & rise) |=> memory_safe_shutdown)
    else $error("safe shutdown missing");
  wake_gate_a: assert property (!ctrl_ff[cpfu_pkg::CPFU_CTRL_PSV] |=> !wake_req)
    else $error("wake while power saving off");
  sim_gate_a: assert property (ctrl_ff[cpfu_pkg::CPFU_CTRL_HOT] |=>
    sim_if_enable == $past(nxt_sim)) else $error("sim interface not gated");
  pin_one_pu_a: assert property (func_ff[0] == cpfu_pkg::CPFU_FN_DPU && vint_on |=>
    gpio_pu[0] && !gpio_oe[0]) else $error("pin one pull-up missing");
  out_drive_a: assert property (func_ff[0] == cpfu_pkg::CPFU_FN_OUT && vint_on |=>
    gpio_oe[0] && gpio_out[0] == $past(out_lvl_ff[0])) else $error("output level wrong");
  aon_pin_a: assert property (!vint_on && func_ff[1] == cpfu_pkg::CPFU_FN_MOD |=>
    gpio_oe[1] && gpio_out[1] == $past(module_on)) else $error("always-on pin dropped");
  mod_stat_a: assert property (func_ff[3] == cpfu_pkg::CPFU_FN_MOD && !module_on |=>
    !gpio_out[3]) else $error("module status wrong");
  irq_level_a: assert property (|(ist_ff & ien_ff) |=> irq) else $error("irq missing");
  apb_wait_a: assert property (acc |=> pready ##1 !pready) else $error("apb timing wrong");

  fast_seen_c: cover property (fast_shutdown);
  reject_seen_c: cover property (done && func_bad);
  sim_insert_c: cover property (sim_ff ##1 sim_if_enable);
  wake_seen_c: cover property (wake_req);
endmodule : cpfu_top

// ---- bench/cpfu_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// host circuitry and card holder switch on the pin side
module cpfu_host_model (
  input  wire logic       pclk,
  input  wire logic [9:0] gpio_out,
  input  wire logic [9:0] gpio_oe,
  input  wire logic [9:0] gpio_pu,
  input  wire logic [9:0] gpio_pd,
  input  wire logic [9:0] drv_en,
  input  wire logic [9:0] drv_val,
  output logic      [9:0] gpio_in
);
  logic [9:0] float_pat;
  // a floating pin toggles so an unknown never reads as a lucky level
  initial float_pat = 10'h155;
  always @(posedge pclk) float_pat <= ~float_pat;
  // switch level, wake level and rising edges
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (gpio_oe[i]) gpio_in[i] = gpio_out[i];
      else if (drv_en[i]) gpio_in[i] = drv_val[i];
      else if (gpio_pu[i]) gpio_in[i] = 1'b1;
      else if (gpio_pd[i]) gpio_in[i] = 1'b0;
      else gpio_in[i] = float_pat[i];
    end
  end
endmodule : cpfu_host_model

// ---- bench/cpfu_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module cpfu_top_tb;
  typedef struct packed {
    logic [3:0] pin;
    logic [3:0] fn;
    logic [4:0] flg;
  } cpfu_row_s;
  // ==========================================================
  // rows: pin, function, {reject, oe, pu, pd, check pulls}
  localparam cpfu_row_s ROWS [20] = '{
    {4'h0, 4'h0, 5'h09}, {4'h2, 4'h2, 5'h13}, {4'h1, 4'h3, 5'h09}, {4'h0, 4'h3, 5'h19},
    {4'h4, 4'h4, 5'h13}, {4'h5, 4'h4, 5'h00}, {4'h7, 4'h5, 5'h09}, {4'h8, 4'h2, 5'h09},
    {4'h2, 4'h6, 5'h01}, {4'h3, 4'h7, 5'h13}, {4'h6, 4'h8, 5'h13}, {4'h9, 4'h9, 5'h13},
    {4'h0, 4'hA, 5'h19}, {4'h9, 4'hB, 5'h13}, {4'h9, 4'h1, 5'h01}, {4'h5, 4'h7, 5'h03},
    {4'h5, 4'h8, 5'h03}, {4'h5, 4'hA, 5'h03}, {4'h0, 4'h9, 5'h05}, {4'h3, 4'h3, 5'h09}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  gpio_in, gpio_out, gpio_oe, gpio_pu, gpio_pd, drv_en, drv_val;
  logic        vint_on, module_on, net_lvl, ring_lvl, sim_present, sim_if_enable;
  logic        wake_req, fast_sd, mem_sd, irq;
  logic [3:0]  exp_fn [10];
  cpfu_row_s   row;
  int          n_mismatch, check_count, n_fast, n_mem;
  cpfu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_pu(gpio_pu), .gpio_pd(gpio_pd), .vint_on(vint_on), .module_on(module_on),
    .net_status_lvl(net_lvl), .ring_indicator_line(ring_lvl), .sim_present(sim_present),
    .sim_if_enable(sim_if_enable), .wake_req(wake_req), .fast_shutdown(fast_sd),
    .memory_safe_shutdown(mem_sd), .irq(irq));
  cpfu_host_model i_host (.pclk(pclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_pu(gpio_pu), .gpio_pd(gpio_pd), .drv_en(drv_en), .drv_val(drv_val),
    .gpio_in(gpio_in));
  // ==========================================================
  // clock, pulse counters, watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (fast_sd === 1'b1) n_fast++;
    if (mem_sd === 1'b1) n_mem++;
  end
  initial begin
    #200us;
    n_mismatch++;
    end_sim();
  end
  // ==========================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic do_reset();
    presetn <= 1'b0;
    cyc(8);
    `CHK(gpio_pu, 10'h001)
    `CHK(gpio_pd, 10'h3FE)
    `CHK({gpio_oe, irq, pready, sim_if_enable}, 13'h001)
    presetn <= 1'b1;
    cyc(1);
  endtask : do_reset
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, drv_en, drv_val} = '0;
    {vint_on, module_on, net_lvl, ring_lvl} = 4'hC;
    foreach (exp_fn[i]) exp_fn[i] = (i == 0) ? 4'h9 : 4'hA;
    do_reset();
    for (int r = 0; r < 20; r++) begin
      row = ROWS[r];
      apb(1'b1, {2'b00, row.pin, 2'b00}, {28'h0, row.fn});
      `CHK(er, row.flg[4])
      if (!row.flg[4]) exp_fn[row.pin] = row.fn;
      cyc(2);
      `CHK(gpio_oe[row.pin], row.flg[3])
      if (row.flg[0]) begin
        `CHK(gpio_pu[row.pin], row.flg[2])
        `CHK(gpio_pd[row.pin], row.flg[1])
      end
      apb(1'b0, {2'b00, row.pin, 2'b00}, 32'h0);
      `CHK(rd, {28'h0, exp_fn[row.pin]})
    end
    // drive levels out, then sense pin 10 as input
    apb(1'b1, 8'h00, 32'h0);
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, 8'h28, v);
      drv_en[9] <= 1'b1;
      drv_val[9] <= v[0];
      {net_lvl, ring_lvl, module_on} <= {3{v[0]}};
      cyc(6);
      `CHK(gpio_out[0], v[0])
      `CHK(gpio_out[8], v[0])
      `CHK(gpio_out[7], v[0])
      `CHK(gpio_out[3], v[0])
      apb(1'b0, 8'h2C, 32'h0);
      `CHK(rd[9], v[0])
    end
    // card switch with hot insertion on, then off
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h30, 32'h2);
    drv_en[5] <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      drv_val[5] <= v[0];
      cyc(8);
      `CHK({sim_present, sim_if_enable}, {2{v[0]}})
    end
    drv_val[5] <= 1'b0;
    cyc(8);
    `CHK(sim_present, 1'b0)
    apb(1'b1, 8'h30, 32'h0);
    cyc(2);
    `CHK(sim_if_enable, 1'b1)
    // shutdown triggers on pin 3 and pin 6
    drv_en[2] <= 1'b1;
    apb(1'b1, 8'h08, 32'h7);
    apb(1'b1, 8'h14, 32'h8);
    cyc(8);
    {n_fast, n_mem} = '0;
    drv_val[2] <= 1'b1;
    drv_val[5] <= 1'b1;
    cyc(10);
    `CHK(n_fast, 1)
    `CHK(n_mem, 1)
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rd[2:1], 2'b11)
    // wake only once power saving is enabled
    apb(1'b1, 8'h08, 32'h6);
    cyc(8);
    `CHK(wake_req, 1'b0)
    apb(1'b1, 8'h30, 32'h1);
    cyc(3);
    `CHK(wake_req, 1'b1)
    // interrupt on a refused function: raise, mask, clear
    apb(1'b1, 8'h38, 32'h1F);
    apb(1'b1, 8'h3C, 32'h10);
    apb(1'b1, 8'h00, 32'h4);
    `CHK(er, 1'b1)
    cyc(2);
    `CHK(irq, 1'b1)
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1'b1, 8'h3C, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h38, 32'h1F);
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    // interface supply off: only always-on pins keep their function
    vint_on <= 1'b0;
    cyc(3);
    `CHK((gpio_oe | gpio_pu | gpio_pd) & ~cpfu_pkg::CPFU_M_AON, 10'h000)
    `CHK(gpio_oe[3], 1'b1)
    vint_on <= 1'b1;
    do_reset();
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rd, 32'hA)
    end_sim();
  end
endmodule : cpfu_top_tb
